// File: logic/efm_pkg.sv
// Constants shared by the encoder feedback monitor and its phase decoder.
// Assumes a 20 MHz system clock and a 16-bit plain register port.
package efm_pkg;
    // Timebase: all programmable times are in tenths of a second.
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam logic [3:0] WIN_LAST = 4'h9;
    localparam int unsigned STARTUP_MS = 2000;
    localparam logic [4:0] STARTUP_TICKS = 5'(STARTUP_MS / TICK_MS);
    localparam logic [15:0] MAX_FREQ_DEF = 16'h0064;

    // Register offsets.
    localparam logic [7:0] ADDR_FAMILY = 8'h00;
    localparam logic [7:0] ADDR_ITYPE = 8'h01;
    localparam logic [7:0] ADDR_PPR = 8'h02;
    localparam logic [7:0] ADDR_SIG_ACT = 8'h03;
    localparam logic [7:0] ADDR_SIG_TMO = 8'h04;
    localparam logic [7:0] ADDR_STALL_LVL = 8'h05;
    localparam logic [7:0] ADDR_STALL_TM = 8'h06;
    localparam logic [7:0] ADDR_SLIP_RNG = 8'h07;
    localparam logic [7:0] ADDR_SLIP_TM = 8'h08;
    localparam logic [7:0] ADDR_SS_ACT = 8'h09;
    localparam logic [7:0] ADDR_STATUS = 8'h0A;
    localparam logic [7:0] ADDR_SPEED = 8'h0B;

    // Encoder families.
    localparam logic [2:0] FAM_OFF = 3'h0;
    localparam logic [2:0] FAM_ABZ_HALL = 3'h2;
    localparam logic [2:0] FAM_SINCOS_SIN = 3'h3;
    localparam logic [2:0] FAM_SER_A = 3'h4;
    localparam logic [2:0] FAM_SER_B = 3'h6;
    localparam logic [15:0] FAM_MAX = 16'h0006;

    // Input types.
    localparam logic [2:0] TYPE_OFF = 3'h0;
    localparam logic [2:0] TYPE_AB = 3'h1;
    localparam logic [2:0] TYPE_BA = 3'h2;
    localparam logic [2:0] TYPE_PD = 3'h3;
    localparam logic [2:0] TYPE_PDN = 3'h4;
    localparam logic [2:0] TYPE_SINGLE = 3'h5;
    localparam logic [15:0] TYPE_MAX = 16'h0005;

    // Reactions.
    localparam logic [1:0] ACT_WARN = 2'h0;
    localparam logic [1:0] ACT_RAMP = 2'h1;
    localparam logic [1:0] ACT_STOP = 2'h2;
    localparam logic [15:0] ACT_MAX = 16'h0002;

    // Reset values and write limits.
    localparam logic [14:0] PPR_RST = 15'h0800;
    localparam logic [15:0] PPR_MAX = 16'h61A8;
    localparam logic [6:0] SIG_TMO_RST = 7'h0A;
    localparam logic [15:0] TENTHS_10S = 16'h0064;
    localparam logic [6:0] STALL_LVL_RST = 7'h73;
    localparam logic [15:0] STALL_LVL_MAX = 16'h0078;
    localparam logic [4:0] STALL_TM_RST = 5'h01;
    localparam logic [15:0] STALL_TM_MAX = 16'h0014;
    localparam logic [5:0] SLIP_RNG_RST = 6'h32;
    localparam logic [15:0] SLIP_RNG_MAX = 16'h0032;
    localparam logic [6:0] SLIP_TM_RST = 7'h05;
endpackage : efm_pkg

// File: logic/efm_decode.sv
// Phase synchroniser and pulse/direction decoder for the encoder inputs.
// Assumes asynchronous encoder and commutation pins.
`timescale 1ns/100ps
`default_nettype none
module efm_decode (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Encoder pins
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    input wire logic [2:0] hall_i,
    // Decode control and results
    input wire logic [2:0] itype_i,
    output logic pulse_o,
    output logic fwd_o,
    output logic [2:0] hall_o
);
    typedef struct packed {
        logic a1;
        logic a2;
        logic a3;
        logic b1;
        logic b2;
        logic [2:0] h1;
        logic [2:0] h2;
        logic pulse;
        logic fwd;
    } efm_dec_state_t;

    efm_dec_state_t q;
    efm_dec_state_t n;
    logic rise;

    // Only the second and third A stages feed edge detection; direction samples the second B stage.
    assign rise = q.a2 & ~q.a3;

    always_comb begin
        n = q;
        n.a1 = enc_a_i;
        n.a2 = q.a1;
        n.a3 = q.a2;
        n.b1 = enc_b_i;
        n.b2 = q.b1;
        n.h1 = hall_i;
        n.h2 = q.h1;
        n.pulse = rise && itype_i != efm_pkg::TYPE_OFF;
        if (rise) begin
            case (itype_i)
                efm_pkg::TYPE_AB: n.fwd = ~q.b2;
                efm_pkg::TYPE_BA: n.fwd = q.b2;
                efm_pkg::TYPE_PD: n.fwd = q.b2;
                efm_pkg::TYPE_PDN: n.fwd = ~q.b2;
                default: n.fwd = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign pulse_o = q.pulse;
    assign fwd_o = q.fwd;
    assign hall_o = q.h2;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_dir_ab;
        rise && itype_i == efm_pkg::TYPE_AB |=> fwd_o == !$past(q.b2);
    endproperty
    a_dir_ab: assert property (p_dir_ab)
        else $error("type 1 dir wrong");
    property p_dir_ba;
        rise && itype_i == efm_pkg::TYPE_BA |=> fwd_o == $past(q.b2);
    endproperty
    a_dir_ba: assert property (p_dir_ba)
        else $error("type 2 dir wrong");
    property p_dir_pd;
        rise && itype_i == efm_pkg::TYPE_PD |=>
            pulse_o && fwd_o == $past(q.b2);
    endproperty
    a_dir_pd: assert property (p_dir_pd)
        else $error("type 3 dir wrong");
    property p_dir_pdn;
        rise && itype_i == efm_pkg::TYPE_PDN |=> fwd_o != $past(q.b2);
    endproperty
    a_dir_pdn: assert property (p_dir_pdn)
        else $error("type 4 dir wrong");
endmodule : efm_decode
`default_nettype wire

// File: logic/efm_monitor.sv
// Encoder feedback monitor: configuration, speed measurement, supervision.
// Assumes a plain register port and motor frequency in Hz on sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
module efm_monitor #(
    parameter int unsigned TICK_CYC = efm_pkg::TICK_CYC,
    parameter logic [15:0] MAX_FREQ_HZ = efm_pkg::MAX_FREQ_DEF
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Encoder pins
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    input wire logic [2:0] hall_i,
    input wire logic enc_loss_i,
    input wire logic enc_sig_err_i,
    // Drive side
    input wire logic [15:0] motor_freq_i,
    output logic [15:0] speed_hz_o,
    output logic dir_fwd_o,
    output logic [2:0] pole_sector_o,
    output logic warn_o,
    output logic ramp_stop_o,
    output logic quick_stop_o,
    output logic fault_o,
    output logic run_permit_o
);
    typedef struct packed {
        logic [2:0] family;
        logic [2:0] itype;
        logic [14:0] ppr;
        logic [1:0] sig_act;
        logic [6:0] sig_tmo;
        logic [6:0] stall_lvl;
        logic [4:0] stall_tm;
        logic [5:0] slip_rng;
        logic [6:0] slip_tm;
        logic [1:0] ss_act;
        logic [15:0] rdata;
        logic [21:0] tick_cnt;
        logic tick;
        logic [3:0] win_cnt;
        logic [14:0] acc;
        logic [15:0] revs;
        logic [15:0] speed;
        logic fwd;
        logic [7:0] sig_tmr;
        logic [7:0] slip_tmr;
        logic [7:0] ss_tmr;
        logic [4:0] boot_tmr;
        logic loss_s1;
        logic loss_s2;
        logic err_s1;
        logic err_s2;
        logic loss_flt;
        logic sig_flt;
        logic stall_flt;
        logic slip_flt;
        logic [2:0] pole;
        logic warn;
        logic ramp;
        logic stop;
    } efm_mon_state_t;

    localparam logic [21:0] TICK_LAST = 22'(TICK_CYC - 1);

    efm_mon_state_t q;
    efm_mon_state_t n;
    logic dec_pulse;
    logic dec_fwd;
    logic [2:0] dec_hall;
    logic en;
    logic setting_err;
    logic sig_cond;
    logic sig_trip;
    logic [15:0] spd_diff;
    logic stall_cond;
    logic slip_cond;
    logic slip_qual;
    logic ss_cond;
    logic ss_trip;
    logic rev_inc;
    logic [3:0] clr;

    function automatic logic sincos(input logic [2:0] fam);
        sincos = fam >= efm_pkg::FAM_SINCOS_SIN;
    endfunction : sincos

    // True when val exceeds pct percent of maxf.
    function automatic logic over_pct(input logic [15:0] val,
                                      input logic [6:0] pct,
                                      input logic [15:0] maxf);
        over_pct = ({16'h0000, val} * 32'h0000_0064) >
                   ({25'h000_0000, pct} * {16'h0000, maxf});
    endfunction : over_pct

    // Counts whole tenths of a second while cond holds, saturating.
    function automatic logic [7:0] tmr_step(input logic [7:0] t,
                                            input logic cond,
                                            input logic tk);
        if (!cond) begin
            tmr_step = 8'h00;
        end else if (tk && t != 8'hFF) begin
            tmr_step = t + 8'h01;
        end else begin
            tmr_step = t;
        end
    endfunction : tmr_step

    efm_decode u_decode (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .enc_a_i(enc_a_i),
        .enc_b_i(enc_b_i),
        .hall_i(hall_i),
        .itype_i(q.itype),
        .pulse_o(dec_pulse),
        .fwd_o(dec_fwd),
        .hall_o(dec_hall)
    );

    assign en = q.family != efm_pkg::FAM_OFF && q.itype != efm_pkg::TYPE_OFF;
    // A family change can leave an illegal type behind; it is then a fault.
    assign setting_err = sincos(q.family) && q.itype >= efm_pkg::TYPE_PD;
    assign sig_cond = en && (q.loss_s2 | q.err_s2 | setting_err);
    // The timer lags its condition by one cycle, so the live condition gates
    // the trip; otherwise a vanishing loss would set a false signal fault.
    assign sig_trip = sig_cond && q.sig_tmr > {1'b0, q.sig_tmo};
    assign spd_diff = (q.speed > motor_freq_i) ? q.speed - motor_freq_i
                                               : motor_freq_i - q.speed;
    assign stall_cond = en && q.stall_lvl != 7'h00 &&
                        over_pct(q.speed, q.stall_lvl, MAX_FREQ_HZ);
    assign slip_cond = en && q.slip_rng != 6'h00 &&
                       over_pct(spd_diff, {1'b0, q.slip_rng},
                                MAX_FREQ_HZ);
    assign slip_qual = q.slip_tmr > {1'b0, q.slip_tm};
    assign ss_cond = slip_qual | stall_cond;
    assign ss_trip = q.ss_tmr > {3'h0, q.stall_tm};
    assign rev_inc = en && dec_pulse && ({1'b0, q.acc} + 16'h0001 >=
                                         {1'b0, q.ppr});
    assign clr = (reg_wr_i && reg_addr_i == efm_pkg::ADDR_STATUS) ?
                 reg_wdata_i[3:0] : 4'h0;

    always_comb begin
        n = q;
        n.tick = 1'b0;
        n.rdata = 16'h0000;
        n.loss_s1 = enc_loss_i;
        n.loss_s2 = q.loss_s1;
        n.err_s1 = enc_sig_err_i;
        n.err_s2 = q.err_s1;
        if (q.tick_cnt == TICK_LAST) begin
            n.tick_cnt = 22'h00_0000;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = q.tick_cnt + 22'h00_0001;
        end
        // Writes out of range are dropped and the old setting stays.
        if (reg_wr_i) begin
            case (reg_addr_i)
                efm_pkg::ADDR_FAMILY: begin
                    if (reg_wdata_i <= efm_pkg::FAM_MAX) begin
                        n.family = reg_wdata_i[2:0];
                    end
                end
                efm_pkg::ADDR_ITYPE: begin
                    if (reg_wdata_i <= efm_pkg::TYPE_MAX &&
                        !(sincos(q.family) &&
                          reg_wdata_i[2:0] >= efm_pkg::TYPE_PD)) begin
                        n.itype = reg_wdata_i[2:0];
                    end
                end
                efm_pkg::ADDR_PPR: begin
                    if (reg_wdata_i != 16'h0000 &&
                        reg_wdata_i <= efm_pkg::PPR_MAX) begin
                        n.ppr = reg_wdata_i[14:0];
                    end
                end
                efm_pkg::ADDR_SIG_ACT: begin
                    if (reg_wdata_i <= efm_pkg::ACT_MAX) begin
                        n.sig_act = reg_wdata_i[1:0];
                    end
                end
                efm_pkg::ADDR_SIG_TMO: begin
                    if (reg_wdata_i <= efm_pkg::TENTHS_10S) begin
                        n.sig_tmo = reg_wdata_i[6:0];
                    end
                end
                efm_pkg::ADDR_STALL_LVL: begin
                    if (reg_wdata_i <= efm_pkg::STALL_LVL_MAX) begin
                        n.stall_lvl = reg_wdata_i[6:0];
                    end
                end
                efm_pkg::ADDR_STALL_TM: begin
                    if (reg_wdata_i <= efm_pkg::STALL_TM_MAX) begin
                        n.stall_tm = reg_wdata_i[4:0];
                    end
                end
                efm_pkg::ADDR_SLIP_RNG: begin
                    if (reg_wdata_i <= efm_pkg::SLIP_RNG_MAX) begin
                        n.slip_rng = reg_wdata_i[5:0];
                    end
                end
                efm_pkg::ADDR_SLIP_TM: begin
                    if (reg_wdata_i <= efm_pkg::TENTHS_10S) begin
                        n.slip_tm = reg_wdata_i[6:0];
                    end
                end
                efm_pkg::ADDR_SS_ACT: begin
                    if (reg_wdata_i <= efm_pkg::ACT_MAX) begin
                        n.ss_act = reg_wdata_i[1:0];
                    end
                end
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                efm_pkg::ADDR_FAMILY: n.rdata = {13'h0000, q.family};
                efm_pkg::ADDR_ITYPE: n.rdata = {13'h0000, q.itype};
                efm_pkg::ADDR_PPR: n.rdata = {1'b0, q.ppr};
                efm_pkg::ADDR_SIG_ACT: n.rdata = {14'h0000, q.sig_act};
                efm_pkg::ADDR_SIG_TMO: n.rdata = {9'h000, q.sig_tmo};
                efm_pkg::ADDR_STALL_LVL: n.rdata = {9'h000, q.stall_lvl};
                efm_pkg::ADDR_STALL_TM: n.rdata = {11'h000, q.stall_tm};
                efm_pkg::ADDR_SLIP_RNG: n.rdata = {10'h000, q.slip_rng};
                efm_pkg::ADDR_SLIP_TM: n.rdata = {9'h000, q.slip_tm};
                efm_pkg::ADDR_SS_ACT: n.rdata = {14'h0000, q.ss_act};
                efm_pkg::ADDR_STATUS: n.rdata = {4'h0, q.stop, q.ramp,
                    q.warn, run_permit_o, q.pole, q.fwd, q.slip_flt,
                    q.stall_flt, q.sig_flt, q.loss_flt};
                efm_pkg::ADDR_SPEED: n.rdata = q.speed;
                default: n.rdata = 16'h0000;
            endcase
        end
        // Speed is whole revolutions per one-second window, so it is coarse.
        if (en && dec_pulse) begin
            n.acc = rev_inc ? 15'h0000 : q.acc + 15'h0001;
            n.fwd = dec_fwd;
        end
        n.revs = q.revs + {15'h0000, rev_inc};
        if (q.tick) begin
            if (q.win_cnt == efm_pkg::WIN_LAST) begin
                n.win_cnt = 4'h0;
                n.speed = n.revs;
                n.revs = 16'h0000;
            end else begin
                n.win_cnt = q.win_cnt + 4'h1;
            end
        end
        if (!en) begin
            n.acc = 15'h0000;
            n.revs = 16'h0000;
            n.speed = 16'h0000;
        end
        n.sig_tmr = tmr_step(q.sig_tmr, sig_cond, q.tick);
        n.slip_tmr = tmr_step(q.slip_tmr, slip_cond, q.tick);
        n.ss_tmr = tmr_step(q.ss_tmr, ss_cond, q.tick);
        // A new event in the clearing cycle keeps its flag set.
        n.loss_flt = (q.loss_flt & ~clr[0]) | (sig_trip & q.loss_s2);
        n.sig_flt = (q.sig_flt & ~clr[1]) | (sig_trip & ~q.loss_s2);
        n.stall_flt = (q.stall_flt & ~clr[2]) | (ss_trip & stall_cond);
        n.slip_flt = (q.slip_flt & ~clr[3]) | (ss_trip & slip_qual);
        n.warn = ((n.loss_flt | n.sig_flt) && n.sig_act == efm_pkg::ACT_WARN)
            || ((n.stall_flt | n.slip_flt) &&
                n.ss_act == efm_pkg::ACT_WARN);
        n.ramp = ((n.loss_flt | n.sig_flt) && n.sig_act == efm_pkg::ACT_RAMP)
            || ((n.stall_flt | n.slip_flt) &&
                n.ss_act == efm_pkg::ACT_RAMP);
        n.stop = ((n.loss_flt | n.sig_flt) && n.sig_act == efm_pkg::ACT_STOP)
            || ((n.stall_flt | n.slip_flt) &&
                n.ss_act == efm_pkg::ACT_STOP);
        if (q.tick && q.boot_tmr != efm_pkg::STARTUP_TICKS) begin
            n.boot_tmr = q.boot_tmr + 5'h01;
        end
        n.pole = (q.family == efm_pkg::FAM_ABZ_HALL) ? dec_hall
                                                     : 3'h0;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.ppr <= efm_pkg::PPR_RST;
            q.sig_act <= efm_pkg::ACT_STOP;
            q.sig_tmo <= efm_pkg::SIG_TMO_RST;
            q.stall_lvl <= efm_pkg::STALL_LVL_RST;
            q.stall_tm <= efm_pkg::STALL_TM_RST;
            q.slip_rng <= efm_pkg::SLIP_RNG_RST;
            q.slip_tm <= efm_pkg::SLIP_TM_RST;
            q.ss_act <= efm_pkg::ACT_STOP;
        end else begin
            q <= n;
        end
    end

    assign reg_rdata_o = q.rdata;
    assign speed_hz_o = q.speed;
    assign dir_fwd_o = q.fwd;
    assign pole_sector_o = q.pole;
    assign warn_o = q.warn;
    assign ramp_stop_o = q.ramp;
    assign quick_stop_o = q.stop;
    assign fault_o = q.ramp | q.stop;
    assign run_permit_o = !(q.family == efm_pkg::FAM_SER_A ||
                            q.family == efm_pkg::FAM_SER_B) ||
                          q.boot_tmr == efm_pkg::STARTUP_TICKS;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_type_reject;
        reg_wr_i && reg_addr_i == efm_pkg::ADDR_ITYPE && sincos(q.family) &&
        reg_wdata_i >= 16'h0003 |=> $stable(q.itype);
    endproperty
    a_type_reject: assert property (p_type_reject)
        else $error("type taken");
    property p_ppr_range;
        q.ppr != 15'h0000 && {1'b0, q.ppr} <= efm_pkg::PPR_MAX;
    endproperty
    a_ppr_range: assert property (p_ppr_range)
        else $error("ppr range");
    property p_sig_fault;
        sig_trip && sig_cond |=> q.loss_flt || q.sig_flt;
    endproperty
    a_sig_fault: assert property (p_sig_fault)
        else $error("no sig fault");
    property p_sig_stop;
        q.sig_flt && q.sig_act == efm_pkg::ACT_STOP |->
            quick_stop_o && fault_o;
    endproperty
    a_sig_stop: assert property (p_sig_stop)
        else $error("no stop");
    property p_ss_warn;
        q.slip_flt && q.ss_act == efm_pkg::ACT_WARN |-> warn_o;
    endproperty
    a_ss_warn: assert property (p_ss_warn)
        else $error("no warn");
    property p_stall_off;
        q.stall_lvl == 7'h00 |-> !stall_cond;
    endproperty
    a_stall_off: assert property (p_stall_off)
        else $error("stall on");
    property p_ss_fault;
        ss_trip && stall_cond |=> q.stall_flt && (ramp_stop_o || quick_stop_o
                                                  || warn_o);
    endproperty
    a_ss_fault: assert property (p_ss_fault)
        else $error("no stall flt");
    property p_ss_timer;
        !ss_cond ##1 !ss_cond |-> q.ss_tmr == 8'h00;
    endproperty
    a_ss_timer: assert property (p_ss_timer)
        else $error("timer kept");
    property p_boot;
        q.family == efm_pkg::FAM_SER_A &&
        q.boot_tmr < efm_pkg::STARTUP_TICKS |-> !run_permit_o;
    endproperty
    a_boot: assert property (p_boot)
        else $error("early permit");
    property p_pole;
        q.family != efm_pkg::FAM_ABZ_HALL ##1 1'b1 |-> pole_sector_o == 3'h0;
    endproperty
    a_pole: assert property (p_pole)
        else $error("pole leak");

    c_stall: cover property (!q.stall_flt ##1 q.stall_flt);
    c_slip: cover property (!q.slip_flt ##1 q.slip_flt);
    c_sig: cover property (!q.sig_flt ##1 q.sig_flt);
    c_permit: cover property (!run_permit_o ##1 run_permit_o);
endmodule : efm_monitor
`default_nettype wire

// File: verif/efm_enc_model.sv
// Behavioural rotary encoder: quadrature or pulse plus direction phases.
// Assumes the bench clock; phases stand still while spin_i is low.
`timescale 1ns/100ps
`default_nettype none
module efm_enc_model (
    // Control
    input wire logic sys_clk_i,
    input wire logic spin_i,
    input wire logic dir_i,
    input wire logic pd_i,
    // Phases
    output logic enc_a_o,
    output logic enc_b_o
);
    logic [2:0] ph = 3'h0;
    logic [1:0] q;
    assign q = ph[2:1];
    // Each state lasts two clocks so that the synchroniser never misses it.
    always @(posedge sys_clk_i) if (spin_i) ph <= ph + 3'h1;
    always_comb begin
        enc_a_o = (pd_i || !dir_i) ? q[1] : q[1] ^ q[0];
        enc_b_o = pd_i ? dir_i : (dir_i ? q[1] : q[1] ^ q[0]);
    end
endmodule : efm_enc_model
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the encoder feedback monitor.
// Assumes efm_pkg and the encoder model; ticks shortened to 20 clocks.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic sys_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, spin = 1'b0;
    logic dir = 1'b1, pd = 1'b0, loss = 1'b0, enc_a, enc_b, fwd, permit;
    logic warn, ramp, stop, flt, serr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, mfreq = 16'h0019, rdata, speed, r;
    logic [2:0] hall = 3'h0, pole;
    int error_cnt = 0, samples_checked = 0;
    localparam logic [15:0] DEF [10] = '{16'h0000, 16'h0000, 16'h0800,
        16'h0002, 16'h000A, 16'h0073, 16'h0001, 16'h0032, 16'h0005, 16'h0002};
    efm_enc_model efm_enc_model_i (.sys_clk_i(sys_clk), .spin_i(spin),
        .dir_i(dir), .pd_i(pd), .enc_a_o(enc_a), .enc_b_o(enc_b));
    efm_monitor #(.TICK_CYC(20)) efm_monitor_i (.sys_clk_i(sys_clk),
        .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .enc_a_i(enc_a),
        .enc_b_i(enc_b), .hall_i(hall), .enc_loss_i(loss),
        .enc_sig_err_i(serr), .motor_freq_i(mfreq), .speed_hz_o(speed),
        .dir_fwd_o(fwd), .pole_sector_o(pole), .warn_o(warn),
        .ramp_stop_o(ramp), .quick_stop_o(stop), .fault_o(flt),
        .run_permit_o(permit));
    initial forever #25 sys_clk = ~sys_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wreg
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), rdata, e);
    endtask : rchk
    function automatic logic exp_dir(input int t, input logic d);
        return (t == 5) ? 1'b1 : ((t % 2 == 1) ? d : !d);
    endfunction : exp_dir
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    initial begin
        cyc(20000);
        error_cnt++;
        conclude();
    end
    initial begin
        void'($urandom(32'h0d9b));
        cyc(6);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) rchk(i[7:0], DEF[i]);
        wreg(efm_pkg::ADDR_FAMILY, 16'h0004);
        cyc(2);
        chk("permit early", permit, 1'b0);
        wreg(efm_pkg::ADDR_ITYPE, 16'h0001);
        wreg(efm_pkg::ADDR_FAMILY, 16'h0003);
        wreg(efm_pkg::ADDR_ITYPE, 16'h0004);
        wreg(efm_pkg::ADDR_FAMILY, 16'h0007);
        wreg(efm_pkg::ADDR_PPR, 16'h61A9);
        rchk(efm_pkg::ADDR_ITYPE, 16'h0001);
        rchk(efm_pkg::ADDR_FAMILY, 16'h0003);
        rchk(efm_pkg::ADDR_PPR, 16'h0800);
        r = 16'($urandom_range(25000, 1));
        wreg(efm_pkg::ADDR_PPR, r);
        rchk(efm_pkg::ADDR_PPR, r);
        rchk(8'h3C, 16'h0000);
        $display("registers done");
        hall <= 3'($urandom_range(6, 1));
        wreg(efm_pkg::ADDR_FAMILY, 16'h0002);
        cyc(5);
        chk("pole", pole, hall);
        wreg(efm_pkg::ADDR_FAMILY, 16'h0001);
        cyc(4);
        chk("pole off", pole, 3'h0);
        $display("pole done");
        for (int t = 1; t < 6; t++) begin
            wreg(efm_pkg::ADDR_ITYPE, 16'(t));
            pd <= (t == 3 || t == 4);
            repeat (2) begin
                dir <= 1'($urandom);
                spin <= 1'b1;
                cyc(40);
                chk("dir", fwd, exp_dir(t, dir));
            end
        end
        {spin, pd, dir} <= 3'b001;
        wreg(efm_pkg::ADDR_ITYPE, 16'h0001);
        for (int f = 0; f < 7; f++) begin
            wreg(efm_pkg::ADDR_FAMILY, 16'(f));
            rchk(efm_pkg::ADDR_FAMILY, 16'(f));
            if (f == 4) chk("permit late", permit, 1'b1);
        end
        $display("direction and family done");
        wreg(efm_pkg::ADDR_FAMILY, 16'h0001);
        wreg(efm_pkg::ADDR_PPR, 16'h0001);
        wreg(efm_pkg::ADDR_STALL_LVL, 16'h0014);
        wreg(efm_pkg::ADDR_SS_ACT, 16'h0001);
        spin <= 1'b1;
        cyc(450);
        chk("speed", speed, 16'h0019);
        chk("stall", {flt, stop, ramp}, 3'b101);
        spin <= 1'b0;
        cyc(450);
        wreg(efm_pkg::ADDR_STATUS, 16'h000F);
        cyc(2);
        chk("stall clear", flt, 1'b0);
        $display("stall done");
        wreg(efm_pkg::ADDR_SIG_TMO, 16'h0002);
        for (int a = 0; a < 3; a++) begin
            wreg(efm_pkg::ADDR_SIG_ACT, 16'(a));
            {serr, loss} <= (a == 1) ? 2'b10 : 2'b01;
            cyc(30);
            chk("loss early", {stop, ramp, warn}, 3'b000);
            cyc(90);
            chk("loss react", {stop, ramp, warn}, 3'b001 << a);
            rchk(efm_pkg::ADDR_STATUS, 16'h0110 | (16'h0200 << a) |
                 ((a == 1) ? 16'h0002 : 16'h0001));
            {serr, loss} <= 2'b00;
            // The flag keeps being set until the pin has left the synchroniser.
            cyc(2);
            wreg(efm_pkg::ADDR_STATUS, 16'h000F);
            cyc(2);
            chk("loss clear", {stop, ramp, warn}, 3'b000);
        end
        $display("loss done");
        wreg(efm_pkg::ADDR_SLIP_RNG, 16'h001E);
        mfreq <= 16'h003C;
        cyc(90);
        chk("slip early", flt, 1'b0);
        cyc(110);
        chk("slip", {flt, stop, ramp}, 3'b101);
        mfreq <= 16'h0019;
        wreg(efm_pkg::ADDR_STATUS, 16'h000F);
        cyc(2);
        chk("slip clear", flt, 1'b0);
        $display("slip done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
